/* dv/aux_regs_test.sv */
`timescale 1ns/10ps
module aux_regs_test
    import aux_regs_pkg::*;
;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        irq, rate_set_two, e;
    logic [7:0]  paddr, output_pins;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  input_lines, change_irq_enable;
    logic [15:0] counter_preset;
    logic [6:0]  src;
    int          err_total, check_count, i;

    aux_regs aux_regs_i (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_lines(input_lines),
        .chan_a_transmit_ready(src[0]),
        .chan_a_receive_ready_or_full(src[1]),
        .chan_a_break_change(src[2]), .counter_ready(src[3]),
        .chan_b_transmit_ready(src[4]),
        .chan_b_receive_ready_or_full(src[5]),
        .chan_b_break_change(src[6]), .output_pins(output_pins),
        .rate_set_two(rate_set_two), .change_irq_enable(change_irq_enable),
        .counter_preset(counter_preset), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and closing report
    initial clock = 1'b0;
    always #4 clock = ~clock;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    ////////////////////////////////////////////////////////////////////////
    // apb transfer: setup, access, hold until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
        cmp({31'h0, e}, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0);
        cmp(q, {24'h000000, x});
        cmp({31'h0, e}, 32'h0);
    endtask : rd

    task automatic irq_is(input logic x);
        repeat (2) @(posedge clock);
        cmp({31'h0, irq}, {31'h0, x});
    endtask : irq_is

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; input_lines = 4'h0; src = 7'h00;
        err_total = 0; check_count = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        cmp({24'h0, output_pins}, 32'h000000ff);
        wr(AUXCTL_OFF, 8'h85);
        cmp({27'h0, rate_set_two, change_irq_enable}, 32'h15);
        wr(AUXCTL_OFF, 8'h0f);
        cmp({27'h0, rate_set_two, change_irq_enable}, 32'h0f);
        wr(CTU_OFF, 8'h5a);
        wr(CTL_OFF, 8'hc3);
        cmp({16'h0, counter_preset}, 32'h5ac3);
        rd(CTL_OFF, 8'hc3);
        wr(SCRATCH_OFF, 8'ha5);
        rd(SCRATCH_OFF, 8'ha5);
        wr(SCRATCH_OFF, 8'h5a);
        rd(SCRATCH_OFF, 8'h5a);
        // output latch set and reset, pins inverted
        wr(OUTSET_OFF, 8'h81);
        irq_is(1'b0);
        cmp({24'h0, output_pins}, 32'h7e);
        wr(OUTSET_OFF, 8'h02);
        irq_is(1'b0);
        cmp({24'h0, output_pins}, 32'h7c);
        wr(OUTRST_OFF, 8'h01);
        irq_is(1'b0);
        cmp({24'h0, output_pins}, 32'h7d);
        // input line change flags, levels and change status
        input_lines <= 4'ha;
        repeat (4) @(posedge clock);
        rd(STAT_MASK_OFF, 8'h80);
        wr(STAT_MASK_OFF, 8'h80);
        irq_is(1'b1);
        rd(IPCHG_OFF, 8'haa);
        rd(IPCHG_OFF, 8'h0a);
        rd(STAT_MASK_OFF, 8'h00);
        irq_is(1'b0);
        // each status source in its own bit, masked and unmasked
        for (i = 0; i < 7; i++) begin
            src <= 7'(1 << i);
            rd(STAT_MASK_OFF, 8'(1 << i));
            wr(STAT_MASK_OFF, 8'(1 << i));
            irq_is(1'b1);
            rd(MASK_RD_OFF, 8'(1 << i));
            wr(STAT_MASK_OFF, ~8'(1 << i));
            irq_is(1'b0);
        end
        wr(STAT_MASK_OFF, 8'h00);
        src <= 7'h00;
        // sticky event status, write one to clear
        wr(EVT_STAT_OFF, 8'hff);
        rd(EVT_STAT_OFF, 8'h00);
        src <= 7'h08;
        @(posedge clock);
        src <= 7'h00;
        wr(EVT_MASK_OFF, 8'h08);
        irq_is(1'b1);
        rd(EVT_STAT_OFF, 8'h08);
        wr(EVT_STAT_OFF, 8'h08);
        rd(EVT_STAT_OFF, 8'h00);
        irq_is(1'b0);
        // unmapped offset is refused and reads zero
        apb(1'b0, 8'h20, 32'h0);
        cmp(q, 32'h0);
        cmp({31'h0, e}, 32'h1);
        apb(1'b1, 8'h24, 32'h000000ff);
        cmp({31'h0, e}, 32'h1);
        rd(SCRATCH_OFF, 8'h5a);
        end_sim();
    end
endmodule : aux_regs_test

/* logic/aux_regs.sv */
`timescale 1ns/10ps
// How it works
// - aux control bit 7 picks rate set
// - change register high nibble: line changed flags
// - change register low nibble: live line levels
// - status bits in documented source order
// - mask bit enables matching status bit
// - sixteen-bit preset from upper, lower bytes
// - set command sets latch bits written one
// - reset command clears latch bits written one
// - output pins drive inverted latch bits
module aux_regs
    import aux_regs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  input_lines,
    input  wire logic        chan_a_transmit_ready,
    input  wire logic        chan_a_receive_ready_or_full,
    input  wire logic        chan_a_break_change,
    input  wire logic        counter_ready,
    input  wire logic        chan_b_transmit_ready,
    input  wire logic        chan_b_receive_ready_or_full,
    input  wire logic        chan_b_break_change,
    output logic      [7:0]  output_pins,
    output logic             rate_set_two,
    output logic      [3:0]  change_irq_enable,
    output logic      [15:0] counter_preset,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]  aux_control;
        logic [7:0]  interrupt_mask;
        logic [7:0]  evt_sticky;
        logic [7:0]  evt_mask;
        logic [15:0] preset;
        logic [7:0]  scratch_pad;
        logic [7:0]  output_latch;
        logic [7:0]  pins;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        irq;
    } regs_state_t;

    regs_state_t st_r;
    regs_state_t st_nxt;
    logic [1:0]  rst_pipe_r;
    logic        rst_sync_b;
    logic [3:0]  level;
    logic [3:0]  delta;
    logic [3:0]  edges;
    logic [7:0]  status;
    logic        wr_en;
    logic        rd_en;
    logic        rd_ipchg;

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe_r[1];

    // decode of a known offset
    function automatic logic known_addr(input logic [7:0] a);
        unique case (a)
            AUXCTL_OFF, STAT_MASK_OFF, CTU_OFF, CTL_OFF, SCRATCH_OFF,
            OUTSET_OFF, OUTRST_OFF, EVT_STAT_OFF, EVT_MASK_OFF,
            MASK_RD_OFF: known_addr = 1'b1;
            default:     known_addr = 1'b0;
        endcase
    endfunction : known_addr

    ////////////////////////////////////////////////////////////////////////
    // apb access phase qualifiers; one answer per access, after one wait state
    assign wr_en    = psel & penable & pwrite & ~st_r.ready;
    assign rd_en    = psel & penable & ~pwrite & ~st_r.ready;
    assign rd_ipchg = rd_en & (paddr == IPCHG_OFF);

    // reading the change register clears its flags
    change_detect #(
        .N(4)
    ) u_change (
        .clock      (clock),
        .rst_sync_b (rst_sync_b),
        .lines      (input_lines),
        .clear      (rd_ipchg),
        .level_r    (level),
        .delta_r    (delta),
        .edge_r     (edges)
    );

    // live status word in documented order
    always_comb begin
        status = {|(delta & st_r.aux_control[3:0]),
                  chan_b_break_change, chan_b_receive_ready_or_full,
                  chan_b_transmit_ready, counter_ready,
                  chan_a_break_change, chan_a_receive_ready_or_full,
                  chan_a_transmit_ready};
    end

    ////////////////////////////////////////////////////////////////////////
    // register file next state
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ready = psel & penable & ~st_r.ready;
        st_nxt.err   = 1'b0;
        if (psel && penable && !st_r.ready && !known_addr(paddr)) begin
            st_nxt.err = 1'b1;
        end
        if (wr_en) begin
            unique case (paddr)
                AUXCTL_OFF:   st_nxt.aux_control    = pwdata[7:0];
                STAT_MASK_OFF: st_nxt.interrupt_mask = pwdata[7:0];
                CTU_OFF:      st_nxt.preset[15:8]   = pwdata[7:0];
                CTL_OFF:      st_nxt.preset[7:0]    = pwdata[7:0];
                SCRATCH_OFF:  st_nxt.scratch_pad    = pwdata[7:0];
                OUTSET_OFF:   st_nxt.output_latch =
                                  st_r.output_latch | pwdata[7:0];
                OUTRST_OFF:   st_nxt.output_latch =
                                  st_r.output_latch & ~pwdata[7:0];
                EVT_STAT_OFF: st_nxt.evt_sticky =
                                  st_r.evt_sticky & ~pwdata[7:0];
                EVT_MASK_OFF: st_nxt.evt_mask       = pwdata[7:0];
                default:      st_nxt.err            = 1'b1;
            endcase
        end
        // sticky event copy; a high status bit wins over a clear
        st_nxt.evt_sticky = st_nxt.evt_sticky | status;
        st_nxt.rdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                IPCHG_OFF:    st_nxt.rdata[7:0] =
                                  {delta, level};
                STAT_MASK_OFF: st_nxt.rdata[7:0] = status;
                CTU_OFF:      st_nxt.rdata[7:0] = st_r.preset[15:8];
                CTL_OFF:      st_nxt.rdata[7:0] = st_r.preset[7:0];
                SCRATCH_OFF:  st_nxt.rdata[7:0] = st_r.scratch_pad;
                EVT_STAT_OFF: st_nxt.rdata[7:0] = st_r.evt_sticky;
                EVT_MASK_OFF: st_nxt.rdata[7:0] = st_r.evt_mask;
                MASK_RD_OFF:  st_nxt.rdata[7:0] = st_r.interrupt_mask;
                default:      st_nxt.rdata      = 32'h0000_0000;
            endcase
        end
        st_nxt.pins = ~st_nxt.output_latch;
        st_nxt.irq  = |(status & st_r.interrupt_mask) |
                      |(st_r.evt_sticky & st_r.evt_mask);
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r      <= '0;
            st_r.pins <= 8'hff;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign prdata            = st_r.rdata;
    assign pready            = st_r.ready;
    assign pslverr           = st_r.err;
    assign output_pins       = st_r.pins;
    assign rate_set_two      = st_r.aux_control[RATE_SET_BIT];
    assign change_irq_enable = st_r.aux_control[3:0];
    assign counter_preset    = st_r.preset;
    assign irq               = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks: output latch and pins
    chk_pins_inverse: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        output_pins == ~st_r.output_latch)
        else $error("output pins not inverse of latch");

    chk_set_cmd: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == OUTSET_OFF) |=>
        ((output_pins & $past(pwdata[7:0])) == 8'h00))
        else $error("set command failed");

    chk_set_keeps: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == OUTSET_OFF) |=>
        ((~output_pins & ~$past(pwdata[7:0])) ==
         (~$past(output_pins) & ~$past(pwdata[7:0]))))
        else $error("set command disturbed other bits");

    chk_reset_cmd: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == OUTRST_OFF) |=>
        ((~output_pins & $past(pwdata[7:0])) == 8'h00))
        else $error("reset command failed");

    chk_reset_keeps: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == OUTRST_OFF) |=>
        ((~output_pins & ~$past(pwdata[7:0])) ==
         (~$past(output_pins) & ~$past(pwdata[7:0]))))
        else $error("reset command disturbed other bits");

    chk_latch_hold: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !(wr_en && (paddr == OUTSET_OFF || paddr == OUTRST_OFF)) |=>
        $stable(output_pins))
        else $error("output pins moved without a command");

    ////////////////////////////////////////////////////////////////////////
    // checks: stored bytes
    chk_scratch_back: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == SCRATCH_OFF) |=>
        (st_r.scratch_pad == $past(pwdata[7:0])))
        else $error("scratch not stored");

    chk_scratch_hold: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !(wr_en && paddr == SCRATCH_OFF) |=>
        $stable(st_r.scratch_pad))
        else $error("scratch changed without a write");

    chk_rate_sel: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == AUXCTL_OFF) |=>
        (rate_set_two == $past(pwdata[7])))
        else $error("rate set wrong");

    chk_rate_hold: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !(wr_en && paddr == AUXCTL_OFF) |=> $stable(rate_set_two))
        else $error("rate set changed without a write");

    chk_enable_copy: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == AUXCTL_OFF) |=>
        (change_irq_enable == $past(pwdata[3:0])))
        else $error("change enables not stored");

    chk_preset_hi: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == CTU_OFF) |=>
        (counter_preset[15:8] == $past(pwdata[7:0])))
        else $error("preset upper wrong");

    chk_preset_lo: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == CTL_OFF) |=>
        (counter_preset[7:0] == $past(pwdata[7:0])))
        else $error("preset lower wrong");

    chk_preset_hold: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !(wr_en && (paddr == CTU_OFF || paddr == CTL_OFF)) |=>
        $stable(counter_preset))
        else $error("preset changed without a write");

    chk_mask_store: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (wr_en && paddr == STAT_MASK_OFF) |=>
        (st_r.interrupt_mask == $past(pwdata[7:0])))
        else $error("mask not stored");

    chk_mask_hold: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !(wr_en && paddr == STAT_MASK_OFF) |=>
        $stable(st_r.interrupt_mask))
        else $error("mask changed without a write");

    ////////////////////////////////////////////////////////////////////////
    // checks: change flags and status word
    chk_change_read: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        rd_ipchg |=> (prdata[7:0] == {$past(delta), $past(level)}))
        else $error("change register read wrong");

    chk_flag_covers: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (edges & ~delta) == 4'h0)
        else $error("detected change not flagged");

    chk_flag_hold: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !rd_ipchg |=> ((delta & $past(delta)) == $past(delta)))
        else $error("change flag lost without a read");

    chk_flag_clear: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        rd_ipchg |=> (delta == edges))
        else $error("change flags not cleared by read");

    chk_status_read: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (rd_en && paddr == STAT_MASK_OFF) |=>
        (prdata[CTR_READY_BIT] == $past(counter_ready)))
        else $error("status order wrong");

    chk_status_change: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (rd_en && paddr == STAT_MASK_OFF) |=>
        (prdata[INPUT_CHG_BIT] ==
         $past(|(delta & change_irq_enable))))
        else $error("status change bit wrong");

    chk_status_ends: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (rd_en && paddr == STAT_MASK_OFF) |=>
        (prdata[6] == $past(chan_b_break_change) &&
         prdata[0] == $past(chan_a_transmit_ready)))
        else $error("status end bits wrong");

    chk_sticky_set: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (|status) |=>
        ((st_r.evt_sticky & $past(status)) == $past(status)))
        else $error("sticky event not captured");

    ////////////////////////////////////////////////////////////////////////
    // checks: interrupt and bus answer
    chk_irq_mask: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        |(status & st_r.interrupt_mask) |=> irq)
        else $error("irq missing");

    chk_irq_quiet: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (!(|(status & st_r.interrupt_mask)) &&
         !(|(st_r.evt_sticky & st_r.evt_mask))) |=> !irq)
        else $error("irq without an enabled condition");

    chk_ready_answer: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (psel && penable && !pready) |=> pready)
        else $error("access not answered");

    chk_ready_pulse: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        pready |=> !pready)
        else $error("ready longer than one cycle");

    chk_err_refused: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        (psel && penable && !pready && !known_addr(paddr)) |=> pslverr)
        else $error("unmapped offset not refused");

    chk_err_with_ready: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        pslverr |-> pready)
        else $error("error without ready");

    chk_rdata_idle: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        !pready |-> (prdata == 32'h0000_0000))
        else $error("read data outside an answer");

    chk_rdata_upper: assert property (
        @(posedge clock) disable iff (!rst_sync_b)
        prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");

endmodule : aux_regs

/* logic/aux_regs_pkg.sv */
package aux_regs_pkg;

    // register byte addresses; the register select field of the map times four
    localparam logic [7:0] STAT_MASK_OFF = 8'h14;
    localparam logic [7:0] AUXCTL_OFF    = 8'h10;
    localparam logic [7:0] IPCHG_OFF     = 8'h10;
    localparam logic [7:0] CTU_OFF       = 8'h18;
    localparam logic [7:0] CTL_OFF       = 8'h1c;
    localparam logic [7:0] SCRATCH_OFF   = 8'h30;
    localparam logic [7:0] OUTSET_OFF    = 8'h38;
    localparam logic [7:0] OUTRST_OFF    = 8'h3c;
    localparam logic [7:0] EVT_STAT_OFF  = 8'h40;
    localparam logic [7:0] EVT_MASK_OFF  = 8'h44;
    localparam logic [7:0] MASK_RD_OFF   = 8'h48;

    // field positions
    localparam int RATE_SET_BIT  = 7;
    localparam int CHG_LO        = 4;
    localparam int LVL_LO        = 0;
    localparam int INPUT_CHG_BIT = 7;
    localparam int CTR_READY_BIT = 3;

    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] OUT_RST  = 8'h00;

endpackage : aux_regs_pkg

/* logic/change_detect.sv */
`timescale 1ns/10ps
// per-line level change detector; a changed flag is held until cleared
module change_detect
    import aux_regs_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic         clock,
    input  wire logic         rst_sync_b,
    input  wire logic [N-1:0] lines,
    input  wire logic         clear,
    output logic      [N-1:0] level_r,
    output logic      [N-1:0] delta_r,
    output logic      [N-1:0] edge_r
);
    typedef struct packed {
        logic [N-1:0] lvl;
        logic [N-1:0] dlt;
        logic [N-1:0] edg;
        logic         primed;
    } cd_state_t;

    cd_state_t st_r;
    cd_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // first sample primes the level so reset gives no false change
    always_comb begin
        st_nxt        = st_r;
        st_nxt.lvl    = lines;
        st_nxt.primed = 1'b1;
        st_nxt.edg    = st_r.primed ? (lines ^ st_r.lvl) : '0;
        if (clear) begin
            st_nxt.dlt = '0;
        end
        st_nxt.dlt = st_nxt.dlt | st_nxt.edg; // set wins over clear
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_r = st_r.lvl;
    assign delta_r = st_r.dlt;
    assign edge_r  = st_r.edg;

endmodule : change_detect
